// File: include/sslp_consts.svh
// Purpose: Named constants for the SRAM sleep control block
// Assumes: 25 MHz core clock, 40 ns period
// Notes:   Times in ns, wake recovery count derived from them
`ifndef SSLP_CONSTS_SVH
`define SSLP_CONSTS_SVH
`define SSLP_CLK_PERIOD_NS   40
`define SSLP_ENTRY_CYCLES    2
`define SSLP_WAKE_REC_NS     20
`define SSLP_WAKE_REC_CYCLES \
  (((`SSLP_WAKE_REC_NS + `SSLP_CLK_PERIOD_NS - 1) / `SSLP_CLK_PERIOD_NS) < 1 ? 1 : \
   ((`SSLP_WAKE_REC_NS + `SSLP_CLK_PERIOD_NS - 1) / `SSLP_CLK_PERIOD_NS))
`endif

// File: include/sslp_pkg.sv
// Purpose: Types for the SRAM sleep control block
// Assumes: Included constants header is available
// Notes:   One-hot power states
package sslp_pkg;
  typedef enum logic [3:0] {
    SSLP_AWAKE   = 4'h1,
    SSLP_ENTER   = 4'h2,
    SSLP_ASLEEP  = 4'h4,
    SSLP_RECOVER = 4'h8
  } sslp_state_t;
endpackage

// File: rtl/sslp_ctrl.sv
// Purpose: Sleep entry, hold and wake recovery control for a burst SRAM
// Assumes: Controller finishes pending work before raising the request
// Notes:   Gates commands and output enable for the memory core
`timescale 1ns/1ps
`include "sslp_consts.svh"

// Notes on behaviour
// - Sleep state is entered two clock cycles after request is seen high.
// - Internal state and array contents are kept untouched across sleep.
// - After request falls, normal operation returns after recovery time.
// - Asleep the device acts deselected, taking no reads or writes.
// - Sleep lasts exactly while request stays high, no timeout.
// - Asleep every input but sleep request is ignored; here reset still forces the state back to awake.
// - Asleep all data outputs are high impedance.
// - Sleep request is an asynchronous active-high input.
module sslp_ctrl
  import sslp_pkg::*;
#(
  parameter int ENTRY_CYCLES = `SSLP_ENTRY_CYCLES,
  parameter int REC_CYCLES   = `SSLP_WAKE_REC_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic sleep_request,
  input  wire logic cmd_select,
  input  wire logic cmd_write,
  input  wire logic data_oe_core,
  output logic      core_select,
  output logic      core_write,
  output logic      data_oe,
  output logic      asleep,
  output logic      recovering
);
  //--------------------------------------------------------------
  // Elaboration checks
  //--------------------------------------------------------------
  // Counts must fit the 8-bit step counter
  if (ENTRY_CYCLES < 1 || ENTRY_CYCLES > 255) begin : g_bad_entry
    $error("ENTRY_CYCLES out of range");
  end
  if (REC_CYCLES < 1 || REC_CYCLES > 255) begin : g_bad_rec
    $error("REC_CYCLES out of range");
  end

  localparam logic [7:0] ENTRY_LAST = 8'(ENTRY_CYCLES - 1);
  localparam logic [7:0] REC_LAST   = 8'(REC_CYCLES - 1);

  //--------------------------------------------------------------
  // Request synchroniser
  //--------------------------------------------------------------
  logic req_sync;

  // Asynchronous pin passes two flops first
  sslp_sync u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (sleep_request),
    .sync_out (req_sync)
  );

  //--------------------------------------------------------------
  // Power state machine
  //--------------------------------------------------------------
  sslp_state_t state_reg;
  sslp_state_t state_next;
  logic [7:0]  cnt_reg;
  logic [7:0]  cnt_next;

  // Counter step shared by entry and recovery timing
  function automatic logic [7:0] cnt_step(input logic [7:0] value);
    cnt_step = value + 8'h01;
  endfunction

  // Next state and counter
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      SSLP_AWAKE: begin
        if (req_sync) begin
          state_next = SSLP_ENTER; // Rising-edge sampling
          cnt_next   = 8'h00;
        end
      end
      SSLP_ENTER: begin
        if (!req_sync) begin
          state_next = SSLP_AWAKE;
        end else if (cnt_reg == ENTRY_LAST) begin
          state_next = SSLP_ASLEEP; // Two-cycle entry
        end else begin
          cnt_next = cnt_step(cnt_reg);
        end
      end
      SSLP_ASLEEP: begin
        if (!req_sync) begin
          state_next = SSLP_RECOVER; // Request low ends sleep into recovery; reset goes straight to awake
          cnt_next   = 8'h00;
        end
      end
      SSLP_RECOVER: begin
        if (req_sync) begin
          state_next = SSLP_ENTER;
          cnt_next   = 8'h00;
        end else if (cnt_reg == REC_LAST) begin
          state_next = SSLP_AWAKE; // Recovery elapsed
        end else begin
          cnt_next = cnt_step(cnt_reg);
        end
      end
    endcase
  end

  // Register state
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= SSLP_AWAKE;
      cnt_reg   <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  //--------------------------------------------------------------
  // Command and output gating
  //--------------------------------------------------------------
  logic sleeping;
  assign sleeping = (state_reg == SSLP_ASLEEP);

  // Deselect and ignore inputs while asleep; array never touched
  assign core_select = cmd_select && !sleeping;
  // Writes also blocked during recovery
  assign core_write  = cmd_select && cmd_write && (state_reg == SSLP_AWAKE
                       || state_reg == SSLP_ENTER);
  // Drivers off while asleep
  assign data_oe     = data_oe_core && !sleeping;
  assign asleep      = sleeping;
  assign recovering  = (state_reg == SSLP_RECOVER);

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------
  sequence req_held_s;
    req_sync [*3];
  endsequence

  property entry_p;
    @(posedge clk) disable iff (reset)
      (state_reg == SSLP_AWAKE) ##0 req_held_s |=> sleeping;
  endproperty

  sleep_entry_a: assert property (entry_p)
    else $error("sleep not entered two cycles after request");

  no_early_a: assert property (@(posedge clk) disable iff (reset)
    $rose(req_sync) && state_reg == SSLP_AWAKE |=> !sleeping ##1 !sleeping)
    else $error("sleep entered too early");

  hold_sleep_a: assert property (@(posedge clk) disable iff (reset)
    sleeping && req_sync |=> sleeping)
    else $error("sleep ended while request high");

  // Leaving sleep always passes through recovery; reset release is excused
  wake_rec_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) && $past(sleeping) |-> sleeping || recovering)
    else $error("left sleep without recovery");

  rec_bound_a: assert property (@(posedge clk) disable iff (reset)
    sleeping && !req_sync |=> recovering ##[1:256] (!recovering))
    else $error("recovery never ends");

  deselect_a: assert property (@(posedge clk) disable iff (reset)
    sleeping |-> !core_select && !core_write)
    else $error("access while asleep");

  hiz_out_a: assert property (@(posedge clk) disable iff (reset)
    sleeping |-> !data_oe)
    else $error("outputs driven while asleep");

  rec_nowrite_a: assert property (@(posedge clk) disable iff (reset)
    recovering |-> !core_write)
    else $error("write during recovery");

  ignore_in_a: assert property (@(posedge clk) disable iff (reset)
    sleeping && $changed(cmd_select) |-> !core_select)
    else $error("input seen while asleep");

  // Step counter frozen while asleep
  state_keep_a: assert property (@(posedge clk) disable iff (reset)
    sleeping && req_sync |=> $stable(cnt_reg))
    else $error("internal state moved while asleep");

  // Request back during recovery restarts the entry count
  rec_reenter_a: assert property (@(posedge clk) disable iff (reset)
    recovering && req_sync |=> (state_reg == SSLP_ENTER))
    else $error("request in recovery not taken");

  // Request gone during entry goes straight back to awake
  enter_abort_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == SSLP_ENTER) && !req_sync |=> (state_reg == SSLP_AWAKE))
    else $error("sleep entry without request");

  // Reads and deselects still pass during recovery
  rec_reads_a: assert property (@(posedge clk) disable iff (reset)
    recovering |-> (core_select == cmd_select))
    else $error("read blocked during recovery");
endmodule

// File: rtl/sslp_sync.sv
// Purpose: Two-stage synchroniser for an asynchronous level
// Assumes: Single clock domain on the output side
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module sslp_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  // Next values of the two stages
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // Register stages
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule

// File: testbench/sslp_host_model.sv
// Purpose: Memory controller that drives the sleep controls
// Assumes: Bench sets the wishes at the falling edge
// Notes:   force_wr lets one scenario issue a refused write
`timescale 1ns/1ps
module sslp_host_model (
  input  wire logic go_sleep,
  input  wire logic want_sel,
  input  wire logic want_wr,
  input  wire logic want_oe,
  input  wire logic force_wr,
  input  wire logic recovering,
  output tri0       sleep_request,
  output wire logic cmd_select,
  output wire logic cmd_write,
  output wire logic data_oe_core
);
  // Request driven only when asked, pull-down holds it low otherwise
  assign sleep_request = go_sleep ? 1'b1 : 1'bz;
  // Commands; writes held back while the memory recovers
  assign cmd_select   = want_sel;
  assign cmd_write    = want_wr & (~recovering | force_wr);
  assign data_oe_core = want_oe;
endmodule

// File: testbench/testbench.sv
// Purpose: Self-checking bench for the sleep controller
// Assumes: 25 MHz clock, inputs change at the falling edge
// Notes:   Rows cover all command mixes awake and asleep
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, reset = 1'b1, go = 1'b0;
  logic sel = 1'b0, wr = 1'b0, oe = 1'b0, fwr = 1'b0;
  tri0  sleep_request;
  wire  cmd_select, cmd_write, data_oe_core;
  logic core_select, core_write, data_oe, asleep, recovering;
  int   n_errors = 0;
  int   n_tests = 0;
  // Rows: sel wr oe, then expected select write oe
  logic [5:0] rows [8] = '{6'h00, 6'h09, 6'h10, 6'h19, 6'h24, 6'h2d, 6'h36, 6'h3f};

  sslp_host_model host (.go_sleep(go), .want_sel(sel), .want_wr(wr), .want_oe(oe),
    .force_wr(fwr), .recovering(recovering), .sleep_request(sleep_request),
    .cmd_select(cmd_select), .cmd_write(cmd_write), .data_oe_core(data_oe_core));
  sslp_ctrl dut (.clk(clk), .reset(reset), .sleep_request(sleep_request),
    .cmd_select(cmd_select), .cmd_write(cmd_write), .data_oe_core(data_oe_core),
    .core_select(core_select), .core_write(core_write), .data_oe(data_oe),
    .asleep(asleep), .recovering(recovering));

  // 40 ns clock
  initial begin
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Apply every row, expected outputs masked
  task automatic run_rows(input logic [2:0] mask);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      {sel, wr, oe} = rows[i][5:3];
      #1 check({core_select, core_write, data_oe}, rows[i][2:0] & mask);
    end
    @(negedge clk);
    {sel, wr, oe} = 3'h0;
  endtask

  task automatic tally_and_finish;
    $display("TB: tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #100us;
    n_errors++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(5);
    reset = 1'b0;
    check({asleep, recovering, 1'b0}, 3'h0);
    run_rows(3'h7);
    $display("TB: awake rows done");
    go = 1'b1; // raised only with no command pending
    cyc(3);
    check({asleep, recovering, 1'b0}, 3'h0);
    cyc(2);
    check({asleep, recovering, 1'b0}, 3'h4);
    run_rows(3'h0);
    cyc(60);
    check({asleep, recovering, 1'b0}, 3'h4);
    $display("TB: sleep done");
    {sel, wr, fwr} = 3'h7;
    go = 1'b0;
    cyc(3);
    check({recovering, core_select, core_write}, 3'h6);
    cyc(1);
    check({asleep, recovering, core_write}, 3'h1);
    {sel, wr, fwr} = 3'h0;
    $display("TB: wake done");
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(8);
    check({asleep, recovering, 1'b0}, 3'h0);
    $display("TB: short pulse done");
    go = 1'b1;
    cyc(6);
    check({asleep, 2'h0}, 3'h4);
    reset = 1'b1;
    cyc(1);
    check({asleep, recovering, 1'b0}, 3'h0);
    go = 1'b0;
    reset = 1'b0;
    cyc(2);
    check({asleep, recovering, core_select}, 3'h0);
    $display("TB: reset done");
    go = 1'b1;
    cyc(6);
    check({asleep, recovering, 1'b0}, 3'h4);
    go = 1'b0;
    cyc(1);
    go = 1'b1;
    cyc(2);
    check({asleep, recovering, core_write}, 3'h2);
    cyc(1);
    check({asleep, recovering, 1'b0}, 3'h0);
    cyc(2);
    check({asleep, recovering, 1'b0}, 3'h4);
    go = 1'b0;
    $display("TB: re-entry done");
    tally_and_finish();
  end
endmodule
